/* srwc_pkg.sv */
/*
 * srwc_pkg: constants and types shared by the sleep, reset-cause and
 * watchdog control block. Assumes a 32-bit APB with 12-bit byte addresses;
 * each register sits at byte address four times its index.
 */
package srwc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_PERIPH = 8;
    localparam int unsigned NUM_ASYNC = 4;

    // register indices; byte address is index times four
    localparam logic [9:0] IDX_WDT_CTRL = 10'h021;
    localparam logic [9:0] IDX_RST_CAUSE = 10'h030;
    localparam logic [9:0] IDX_SLEEP_CTRL = 10'h031;
    localparam logic [9:0] IDX_PWR_RED = 10'h032;
    localparam logic [9:0] IDX_CORE_STAT = 10'h033;

    // watchdog_control fields
    localparam int unsigned WDT_TIMEOUT_FLAG_B = 7;
    localparam int unsigned WDT_INTERRUPT_ENABLE_B = 6;
    localparam int unsigned WDT_PRESCALER_BIT3_B = 5;
    localparam int unsigned WDT_CHANGE_ENABLE_B = 4;
    localparam int unsigned WDE_B = 3;
    localparam int unsigned WDP_LSB = 0;
    localparam logic [7:0] WDT_RESET = 8'h00;

    // reset_cause_status fields
    localparam int unsigned WATCHDOG_RESET_FLAG_B = 3;
    localparam int unsigned BROWNOUT_RESET_FLAG_B = 2;
    localparam int unsigned EXTERNAL_RESET_FLAG_B = 1;
    localparam int unsigned POWERON_RESET_FLAG_B = 0;
    localparam logic [3:0] RST_CAUSE_RESET = 4'h1;

    // sleep control fields
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned SE_B = 2;
    localparam int unsigned STATE_LSB = 8;
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_ADCNR = 2'h1;
    localparam logic [1:0] MODE_PDOWN = 2'h2;
    localparam logic [1:0] MODE_STBY = 2'h3;

    // core status field and misc reset values
    localparam int unsigned GIE_B = 7;
    localparam logic [7:0] PWR_RED_RESET = 8'h00;

    // wake-up delays in clock cycles
    localparam logic [2:0] WAKE_STBY_CYC = 3'h6;
    localparam logic [2:0] WAKE_FAST_CYC = 3'h1;

    // async input positions in the synchroniser bundle
    localparam int unsigned AS_EXT = 0;
    localparam int unsigned AS_BOR = 1;
    localparam int unsigned AS_EXTERNAL_INTERRUPT_ZERO = 2;
    localparam int unsigned AS_PCHG = 3;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_IDLE = 6'h02,
        ST_ADCNR = 6'h04,
        ST_PDOWN = 6'h08,
        ST_STBY = 6'h10,
        ST_WAKE = 6'h20
    } srwc_state_t;
endpackage : srwc_pkg

/* srwc_sync.sv */
/*
 * srwc_sync: three-stage synchroniser for a bundle of pin levels.
 * Assumes each bit is an independent slow level; output follows once the
 * second and third stages agree.
 */
`timescale 1ns/1ps
module srwc_sync #(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import srwc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } srwc_sync_t;

    srwc_sync_t st;
    srwc_sync_t next_st;

    // stage one feeds only stage two; filter on stages two and three
    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.q;
endmodule : srwc_sync

/* srwc_top.sv */
/*
 * srwc_top: sleep-mode clock gating, wake filtering, per-peripheral clock
 * stop, reset-cause flags, watchdog mode control and global interrupt gate.
 * Assumes presetn is the power-on reset, an APB master on pclk, and that
 * interrupt request inputs are already qualified by their own enables.
 */
// Behaviour
// - select 01 plus sleep: stop io, cpu, flash clocks; adc, irqs, watchdog run
// - adc noise mode wakes on adc done, resets, spm ready, external_interrupt_zero level, pin change
// - entering idle or adc noise mode starts an adc conversion if enabled
// - select 10 plus sleep: power-down, oscillator and all generated clocks stop
// - power-down wakes only on resets, external_interrupt_zero level or pin change
// - select 11 with crystal: standby, oscillator kept; wake takes six cycles
// - idle wakes on external and internal interrupts
// - power-reduction bit stops a peripheral clock and blocks its registers
// - clearing the bit restarts the clock with state unchanged
// - reset-cause bit 3 set by watchdog reset; cleared by power-on or write 0
// - reset-cause bit 2 set by brown-out; cleared by power-on or write 0
// - reset-cause bit 1 set by external reset; cleared by power-on or write 0
// - reset-cause bit 0 set by power-on; cleared only by writing 0
// - reset-cause bits 7:4 read as zero
// - watchdog control at index 0x21 with the documented bit layout
// - timeout flag set in interrupt mode; cleared by vector or writing one
// - enable set, reset enable clear, global enable on: interrupt not reset
// - with reset enable set, timeout clears interrupt enable
// - global enable gates interrupts; cleared on entry, set on return
`timescale 1ns/1ps
module srwc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srwc_pkg::ADDR_W-1:0] paddr,
    input wire logic [srwc_pkg::DATA_W-1:0] pwdata,
    output logic [srwc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic adc_enabled,
    input wire logic crystal_option,
    input wire logic ext_reset_pin,
    input wire logic brownout_det,
    input wire logic external_interrupt_zero_level_irq,
    input wire logic pin_change_irq,
    input wire logic adc_done_irq,
    input wire logic spm_ready_irq,
    input wire logic ext_edge_irq,
    input wire logic io_irq,
    input wire logic wdt_timeout,
    input wire logic irq_taken,
    input wire logic wdt_vector_taken,
    input wire logic return_from_interrupt,
    output logic clk_cpu_en,
    output logic clk_io_en,
    output logic clk_flash_en,
    output logic adc_clk_en,
    output logic osc_en,
    output logic [srwc_pkg::NUM_PERIPH-1:0] periph_clk_en,
    output logic [srwc_pkg::NUM_PERIPH-1:0] periph_access_block,
    output logic adc_start,
    output logic wdt_irq,
    output logic wdt_reset_req,
    output logic global_irq_enable,
    output logic [3:0] wdt_prescaler
);
    import srwc_pkg::*;

    typedef struct packed {
        srwc_state_t state;
        logic [2:0] wake_cnt;
        logic [7:0] wdt_ctrl;
        logic [3:0] rst_cause;
        logic [1:0] mode;
        logic sleep_en;
        logic [NUM_PERIPH-1:0] pwr_red;
        logic gie;
        logic adc_start;
        logic wdt_rst;
        logic ext_prev;
        logic bor_prev;
        logic [DATA_W-1:0] rdata;
    } srwc_top_t;

    srwc_top_t st;
    srwc_top_t next_st;
    logic [NUM_ASYNC-1:0] pin_sync;
    logic ext_rise;
    logic bor_rise;
    logic rst_evt;
    logic wake;
    logic wr_acc;
    logic rd_setup;
    logic hit_any;
    logic [9:0] idx;
    logic [DATA_W-1:0] rd_mux;
    logic wdt_to_irq;
    logic wdt_to_rst;

    // reset and wake pins come from other domains
    srwc_sync #(
        .W(NUM_ASYNC)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({pin_change_irq, external_interrupt_zero_level_irq, brownout_det, ext_reset_pin}),
        .sync_out(pin_sync)
    );

    // bus decode; only word-aligned hits are mapped
    assign idx = paddr[ADDR_W-1:2];
    assign hit_any = (paddr[1:0] == 2'h0) &&
        (idx == IDX_WDT_CTRL || idx == IDX_RST_CAUSE || idx == IDX_SLEEP_CTRL ||
         idx == IDX_PWR_RED || idx == IDX_CORE_STAT);
    assign wr_acc = psel && penable && pwrite && hit_any;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = st.rdata;

    // reset events and watchdog timeout split by mode
    assign ext_rise = pin_sync[AS_EXT] && !st.ext_prev;
    assign bor_rise = pin_sync[AS_BOR] && !st.bor_prev;
    assign wdt_to_irq = wdt_timeout && st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B];
    assign wdt_to_rst = wdt_timeout && !st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] && st.wdt_ctrl[WDE_B];
    assign rst_evt = st.wdt_rst || ext_rise || bor_rise;

    // watchdog interrupt only when flag, enable and global gate all hold
    assign wdt_irq = st.wdt_ctrl[WDT_TIMEOUT_FLAG_B] && st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] && st.gie;

    // wake filter per sleeping state
    always_comb begin
        case (st.state)
            ST_IDLE: wake = rst_evt || adc_done_irq || spm_ready_irq ||
                pin_sync[AS_EXTERNAL_INTERRUPT_ZERO] || pin_sync[AS_PCHG] || ext_edge_irq ||
                io_irq || wdt_irq;
            ST_ADCNR: wake = rst_evt || adc_done_irq || spm_ready_irq ||
                pin_sync[AS_EXTERNAL_INTERRUPT_ZERO] || pin_sync[AS_PCHG];
            ST_PDOWN, ST_STBY: wake = rst_evt || pin_sync[AS_EXTERNAL_INTERRUPT_ZERO] ||
                pin_sync[AS_PCHG];
            default: wake = 1'b0;
        endcase
    end

    // read mux; reserved bits stay zero
    always_comb begin
        rd_mux = '0;
        case (idx)
            IDX_WDT_CTRL: rd_mux[7:0] = st.wdt_ctrl;
            IDX_RST_CAUSE: rd_mux[3:0] = st.rst_cause;
            IDX_SLEEP_CTRL: begin
                rd_mux[MODE_LSB +: 2] = st.mode;
                rd_mux[SE_B] = st.sleep_en;
                rd_mux[STATE_LSB +: 6] = st.state;
            end
            IDX_PWR_RED: rd_mux[NUM_PERIPH-1:0] = st.pwr_red;
            IDX_CORE_STAT: rd_mux[GIE_B] = st.gie;
            default: rd_mux = '0;
        endcase
    end

    // next-state: registers, flags and sleep sequencer
    always_comb begin
        next_st = st;
        next_st.adc_start = 1'b0;
        next_st.wdt_rst = wdt_to_rst;
        next_st.ext_prev = pin_sync[AS_EXT];
        next_st.bor_prev = pin_sync[AS_BOR];
        if (rd_setup) begin
            next_st.rdata = hit_any ? rd_mux : '0;                            // misaligned reads give zero
        end
        // software writes first so hardware events below win
        if (wr_acc) begin
            case (idx)
                IDX_WDT_CTRL: begin
                    next_st.wdt_ctrl[6:0] = pwdata[6:0];
                    if (pwdata[WDT_TIMEOUT_FLAG_B]) begin
                        next_st.wdt_ctrl[WDT_TIMEOUT_FLAG_B] = 1'b0;
                    end
                end
                IDX_RST_CAUSE: next_st.rst_cause = st.rst_cause & pwdata[3:0];
                IDX_SLEEP_CTRL: begin
                    next_st.mode = pwdata[MODE_LSB +: 2];
                    next_st.sleep_en = pwdata[SE_B];
                end
                IDX_PWR_RED: next_st.pwr_red = pwdata[NUM_PERIPH-1:0];
                IDX_CORE_STAT: next_st.gie = pwdata[GIE_B];
                default: next_st.rst_cause = st.rst_cause;
            endcase
        end
        // vector fetch clears the flag; a new timeout in that cycle wins
        if (wdt_vector_taken) begin
            next_st.wdt_ctrl[WDT_TIMEOUT_FLAG_B] = 1'b0;
        end
        if (wdt_to_irq) begin
            next_st.wdt_ctrl[WDT_TIMEOUT_FLAG_B] = 1'b1;
            if (st.wdt_ctrl[WDE_B]) begin
                next_st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] = 1'b0;
            end
        end
        // interrupt entry drops the global gate; return reopens it
        if (return_from_interrupt) begin
            next_st.gie = 1'b1;
        end
        if (irq_taken) begin
            next_st.gie = 1'b0;
        end
        // reset causes: hardware set beats a software clear
        if (st.wdt_rst) begin
            next_st.rst_cause[WATCHDOG_RESET_FLAG_B] = 1'b1;
        end
        if (bor_rise) begin
            next_st.rst_cause[BROWNOUT_RESET_FLAG_B] = 1'b1;
        end
        if (ext_rise) begin
            next_st.rst_cause[EXTERNAL_RESET_FLAG_B] = 1'b1;
        end
        case (st.state)
            ST_ACTIVE: begin
                if (sleep_exec && st.sleep_en) begin
                    case (st.mode)
                        MODE_IDLE: next_st.state = ST_IDLE;
                        MODE_ADCNR: next_st.state = ST_ADCNR;
                        MODE_PDOWN: next_st.state = ST_PDOWN;
                        // without a crystal option standby falls back to power-down
                        default: next_st.state = crystal_option ? ST_STBY : ST_PDOWN;
                    endcase
                    if (adc_enabled && (st.mode == MODE_IDLE || st.mode == MODE_ADCNR)) begin
                        next_st.adc_start = 1'b1;
                    end
                end
            end
            ST_IDLE, ST_ADCNR, ST_PDOWN, ST_STBY: begin
                if (wake) begin
                    next_st.state = ST_WAKE;
                    next_st.wake_cnt = (st.state == ST_STBY) ?
                        WAKE_STBY_CYC - 3'h1 : WAKE_FAST_CYC - 3'h1;
                end
            end
            ST_WAKE: begin
                if (st.wake_cnt == 3'h0) begin
                    next_st.state = ST_ACTIVE;
                end else begin
                    next_st.wake_cnt = st.wake_cnt - 3'h1;
                end
            end
            default: next_st.state = ST_ACTIVE;
        endcase
    end

    // power-on reset: only the power-on cause is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{state: ST_ACTIVE, wake_cnt: 3'h0, wdt_ctrl: WDT_RESET,
                    rst_cause: RST_CAUSE_RESET, mode: MODE_IDLE, sleep_en: 1'b0,
                    pwr_red: PWR_RED_RESET, gie: 1'b0, adc_start: 1'b0,
                    wdt_rst: 1'b0, ext_prev: 1'b0, bor_prev: 1'b0,
                    rdata: '0};
        end else begin
            st <= next_st;
        end
    end

    // clock enables decoded from the one-hot state flops
    assign clk_cpu_en = (st.state == ST_ACTIVE);
    assign clk_flash_en = (st.state == ST_ACTIVE);
    assign clk_io_en = (st.state == ST_ACTIVE) || (st.state == ST_IDLE);
    assign adc_clk_en = (st.state == ST_ACTIVE) || (st.state == ST_IDLE) ||
        (st.state == ST_ADCNR);
    assign osc_en = (st.state != ST_PDOWN);
    // stopped peripherals freeze; their registers stay intact meanwhile
    assign periph_clk_en = ~st.pwr_red & {NUM_PERIPH{clk_io_en}};
    assign periph_access_block = st.pwr_red;
    assign adc_start = st.adc_start;
    assign wdt_reset_req = st.wdt_rst;
    assign global_irq_enable = st.gie;
    assign wdt_prescaler = {st.wdt_ctrl[WDT_PRESCALER_BIT3_B], st.wdt_ctrl[WDP_LSB +: 3]};

    // checks of the sleep, watchdog and flag behaviour
    chk_adcnr_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_ADCNR |-> !clk_io_en && !clk_cpu_en && adc_clk_en && osc_en)
        else $error("adc noise mode clock gating wrong");
    chk_pdown_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_PDOWN |-> !osc_en && !clk_io_en && !adc_clk_en)
        else $error("power-down left a clock running");
    chk_stby_wake: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_STBY && wake |=> (st.state == ST_WAKE)[*6]
        ##1 st.state == ST_ACTIVE)
        else $error("standby wake not six cycles");
    chk_pdown_wake: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_PDOWN && !rst_evt && !pin_sync[AS_EXTERNAL_INTERRUPT_ZERO] && !pin_sync[AS_PCHG]
        |=> st.state == ST_PDOWN)
        else $error("power-down woke on a disallowed source");
    chk_adc_autostart: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st.state == ST_IDLE || st.state == ST_ADCNR) && $past(adc_enabled)
        |-> adc_start)
        else $error("no adc start on sleep entry");
    chk_prr_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (periph_clk_en & st.pwr_red) == '0)
        else $error("stopped peripheral still clocked");
    chk_watchdog_reset_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_reset_req |=> st.rst_cause[WATCHDOG_RESET_FLAG_B])
        else $error("watchdog reset flag not set");
    chk_wdt_interrupt_enable_autoclr: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_timeout && st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] && st.wdt_ctrl[WDE_B]
        |=> !st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] && st.wdt_ctrl[WDT_TIMEOUT_FLAG_B])
        else $error("interrupt enable not cleared at timeout");
    chk_wdt_irq_mode: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_timeout && st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] && !st.wdt_ctrl[WDE_B] && st.gie
        && !irq_taken |=> wdt_irq && !wdt_reset_req)
        else $error("watchdog interrupt mode misbehaved");
    chk_gie_entry: assert property (@(posedge pclk) disable iff (!presetn)
        irq_taken |=> !global_irq_enable ##0 !wdt_irq)
        else $error("global enable not cleared on entry");
    chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && idx == IDX_RST_CAUSE |-> prdata[7:4] == 4'h0)
        else $error("reserved cause bits not zero");
    // idle stops cpu and flash; io side and oscillator stay alive
    chk_idle_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_IDLE |-> clk_io_en && !clk_cpu_en && !clk_flash_en && osc_en)
        else $error("idle mode clock gating wrong");
    chk_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_WAKE && st.wake_cnt == 3'h0 |=> clk_cpu_en && clk_flash_en)
        else $error("clocks not resumed after wake");
    chk_brownout_reset_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        bor_rise |=> st.rst_cause[BROWNOUT_RESET_FLAG_B])
        else $error("brown-out reset flag not set");
    chk_external_reset_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rise |=> st.rst_cause[EXTERNAL_RESET_FLAG_B])
        else $error("external reset flag not set");
    chk_wdt_timeout_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_timeout && st.wdt_ctrl[WDT_INTERRUPT_ENABLE_B] |=> st.wdt_ctrl[WDT_TIMEOUT_FLAG_B])
        else $error("timeout flag not set in interrupt mode");

    cov_stby_cycle: cover property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_STBY ##[1:50] st.state == ST_ACTIVE);
    cov_wdt_reset: cover property (@(posedge pclk) disable iff (!presetn)
        wdt_reset_req);
    cov_adcnr_wake: cover property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_ADCNR && adc_done_irq);
    cov_idle_wake: cover property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_IDLE && wake);
    cov_pdown_pin: cover property (@(posedge pclk) disable iff (!presetn)
        st.state == ST_PDOWN && pin_sync[AS_PCHG]);
endmodule : srwc_top

/* tb_top.sv */
/*
 * tb_top: self-checking bench for srwc_top; drives apb, sleep, wake and
 * watchdog inputs directly. Assumes the srwc_pkg register map and timing.
 */
`timescale 1ns/1ps
module tb_top;
    import srwc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, sleep_exec = 1'b0, adc_enabled = 1'b0, crystal_option = 1'b0;
    logic ext_reset_pin = 1'b0, brownout_det = 1'b0, external_interrupt_zero_level_irq = 1'b0;
    logic pin_change_irq = 1'b0, adc_done_irq = 1'b0, spm_ready_irq = 1'b0;
    logic ext_edge_irq = 1'b0, io_irq = 1'b0, wdt_timeout = 1'b0, irq_taken = 1'b0;
    logic wdt_vector_taken = 1'b0, return_from_interrupt = 1'b0;
    logic clk_cpu_en, clk_io_en, clk_flash_en, adc_clk_en, osc_en, adc_start;
    logic wdt_irq, wdt_reset_req, global_irq_enable, ae, x;
    logic [7:0] periph_clk_en, periph_access_block, v;
    logic [3:0] wdt_prescaler;
    logic [4:0] en;
    int n_mismatch = 0, comparisons = 0, n, m;
    int seed = 32'ha46e2ab3;
    localparam logic [11:0] A_WDT = {IDX_WDT_CTRL, 2'b00};
    localparam logic [11:0] A_RST = {IDX_RST_CAUSE, 2'b00};
    localparam logic [11:0] A_SLP = {IDX_SLEEP_CTRL, 2'b00};
    localparam logic [11:0] A_PR = {IDX_PWR_RED, 2'b00};

    srwc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_exec(sleep_exec), .adc_enabled(adc_enabled),
        .crystal_option(crystal_option), .ext_reset_pin(ext_reset_pin),
        .brownout_det(brownout_det), .external_interrupt_zero_level_irq(external_interrupt_zero_level_irq),
        .pin_change_irq(pin_change_irq), .adc_done_irq(adc_done_irq),
        .spm_ready_irq(spm_ready_irq), .ext_edge_irq(ext_edge_irq), .io_irq(io_irq),
        .wdt_timeout(wdt_timeout), .irq_taken(irq_taken), .wdt_vector_taken(wdt_vector_taken),
        .return_from_interrupt(return_from_interrupt), .clk_cpu_en(clk_cpu_en),
        .clk_io_en(clk_io_en), .clk_flash_en(clk_flash_en), .adc_clk_en(adc_clk_en),
        .osc_en(osc_en), .periph_clk_en(periph_clk_en),
        .periph_access_block(periph_access_block), .adc_start(adc_start), .wdt_irq(wdt_irq),
        .wdt_reset_req(wdt_reset_req), .global_irq_enable(global_irq_enable),
        .wdt_prescaler(wdt_prescaler));

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, r);
    endtask : rd

    task automatic tmo;
        @(posedge pclk) wdt_timeout <= 1'b1;
        @(posedge pclk) wdt_timeout <= 1'b0;
        #1;
    endtask : tmo

    // expected {cpu, io, flash, adc, osc} enables in each sleep mode
    function automatic logic [4:0] exp_en(input int md, input logic xt);
        case (md)
            0: return 5'h0b;
            1: return 5'h03;
            3: return xt ? 5'h01 : 5'h00;
            default: return 5'h00;
        endcase
    endfunction : exp_en

    // hang guard: the bench must finish well inside this bound
    initial begin
        repeat (50000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_RST, 32'h1, "cause_reset");
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        wr_cause: apb(1'b1, A_RST, 32'h0);
        rd(A_RST, 32'h0, "cause_clear");
        // prescaler and change-enable bits stored as written
        repeat (3) begin
            v = 8'($random(seed)) & 8'h37;
            apb(1'b1, A_WDT, {24'h0, v});
            #1 chk("prescaler", {v[5], v[2:0]}, wdt_prescaler);
            rd(A_WDT, {24'h0, v}, "wdt_ctrl");
        end
        // misaligned access is refused and reads zero
        rd(A_WDT | 12'h001, 32'h0, "misaligned_rd");
        chk("misaligned_err", 32'h1, {31'h0, e});
        // interrupt mode: flag, vector clear, global gate, write-one clear
        apb(1'b1, 12'h0cc, 32'h80);
        apb(1'b1, A_WDT, 32'h40);
        tmo();
        chk("wdt_irq_set", 1, wdt_irq);
        @(posedge pclk) begin irq_taken <= 1'b1; wdt_vector_taken <= 1'b1; end
        @(posedge pclk) begin irq_taken <= 1'b0; wdt_vector_taken <= 1'b0; end
        #1 chk("gie_taken", 2'b00, {wdt_irq, global_irq_enable});
        tmo();
        chk("gated_irq", 0, wdt_irq);
        @(posedge pclk) return_from_interrupt <= 1'b1;
        @(posedge pclk) return_from_interrupt <= 1'b0;
        #1 chk("gie_return", 2'b11, {wdt_irq, global_irq_enable});
        // software puts back the status it saved before the interrupt
        apb(1'b1, 12'h0cc, 32'h80);
        rd(12'h0cc, 32'h80, "core_stat");
        apb(1'b1, A_WDT, 32'hc0);
        rd(A_WDT, 32'h40, "flag_w1c");
        apb(1'b1, A_WDT, 32'h48);
        tmo();
        rd(A_WDT, 32'h88, "ie_autoclr");
        tmo();
        chk("reset_req", 1, wdt_reset_req);
        apb(1'b1, A_WDT, 32'h88);
        // every sleep mode: clocks, adc start, refused sources, wake latency
        for (int i = 0; i < 5; i++) begin
            m = (i == 4) ? 3 : i;
            x = (i != 4);
            ae = (i == 0) || 1'($random(seed));
            apb(1'b1, A_SLP, 32'h4 | m);
            @(posedge pclk) begin crystal_option <= x; adc_enabled <= ae; sleep_exec <= 1'b1; end
            @(posedge pclk) sleep_exec <= 1'b0;
            #1 en = {clk_cpu_en, clk_io_en, clk_flash_en, adc_clk_en, osc_en};
            chk("sleep_clocks", exp_en(m, x), en);
            chk("adc_start", ae && m < 2, adc_start);
            chk("periph_sleep", {8{1'(exp_en(m, x) >> 3)}}, periph_clk_en);
            if (m != 0) begin
                @(posedge pclk) begin io_irq <= 1'b1; adc_done_irq <= (m >= 2); end
                ext_edge_irq <= 1'b1;
                spm_ready_irq <= (m >= 2);
                repeat (4) @(posedge pclk);
                io_irq <= 1'b0;
                adc_done_irq <= 1'b0;
                ext_edge_irq <= 1'b0;
                spm_ready_irq <= 1'b0;
                #1 chk("no_wake", 0, clk_cpu_en);
            end
            // idle: io request; adc noise: external_interrupt_zero level; power-down: pin change; else reset
            @(posedge pclk) begin io_irq <= (m == 0); wdt_timeout <= (m == 3); end
            external_interrupt_zero_level_irq <= (m == 1);
            pin_change_irq <= (m == 2);
            n = 0;
            do begin
                @(posedge pclk);
                io_irq <= 1'b0;
                wdt_timeout <= 1'b0;
                n++;
                #1;
            end while (clk_cpu_en !== 1'b1 && n < 20);
            chk("wake_cycles", (m == 0) ? 2 : (m != 3) ? 6 : x ? 8 : 3, n);
            if (n >= 20) begin
                end_of_test();
            end
            @(posedge pclk) external_interrupt_zero_level_irq <= 1'b0;
            pin_change_irq <= 1'b0;
        end
        // brown-out and external reset pins reach the cause flags
        @(posedge pclk) brownout_det <= 1'b1;
        repeat (6) @(posedge pclk);
        brownout_det <= 1'b0;
        ext_reset_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        ext_reset_pin <= 1'b0;
        rd(A_RST, 32'h0e, "cause_flags");
        apb(1'b1, A_RST, 32'hfb);
        rd(A_RST, 32'h0a, "cause_partial");
        // per-peripheral clock stop and restart
        repeat (4) begin
            v = 8'($random(seed));
            apb(1'b1, A_PR, {24'h0, v});
            #1 chk("pr_block", v, periph_access_block);
            chk("pr_clk", 8'(~v), periph_clk_en);
        end
        apb(1'b1, A_PR, 32'h0);
        #1 chk("pr_restart", 8'hff, periph_clk_en);
        // power-on reset in mid-run clears the other causes
        @(posedge pclk) presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_RST, 32'h1, "cause_por");
        rd(A_WDT, 32'h0, "wdt_por");
        end_of_test();
    end
endmodule : tb_top
